// File: vit_defines.vh
// Constants of the vectored interrupt table: offsets, fields, resets, vectors
`ifndef VIT_DEFINES_VH
`define VIT_DEFINES_VH

// ====================================================================
// Register byte offsets
`define VIT_OFS_REQ      12'h000
`define VIT_OFS_MASK     12'h004
`define VIT_OFS_PRIO     12'h008
`define VIT_OFS_EDGE     12'h00c
`define VIT_OFS_CTRL     12'h010
`define VIT_OFS_VEC      12'h014

// ====================================================================
// Source counts and flag positions
`define VIT_NMSK         19
`define VIT_NFLG         21
`define VIT_NEXT         7
`define VIT_BIT_WDT      0
`define VIT_BIT_EXT0     1
`define VIT_BIT_EXT3     4
`define VIT_BIT_CSI0     8
`define VIT_BIT_CSI1     9
`define VIT_BIT_RXERR    10
`define VIT_BIT_RX2      11
`define VIT_BIT_TX2      12
`define VIT_BIT_WTINT    13
`define VIT_BIT_CC0      14
`define VIT_BIT_CC1      15
`define VIT_BIT_TM8A     16
`define VIT_BIT_TM8B     17
`define VIT_BIT_CONV     18
`define VIT_BIT_WTOVF    19
`define VIT_BIT_KEY      20

// ====================================================================
// Reset values
`define VIT_RST_REQ      21'h000000
`define VIT_RST_MASK     21'h1fffff
`define VIT_RST_PRIO     19'h7ffff
`define VIT_RST_EDGE     7'h00
`define VIT_RST_CTRL     2'h0

// ====================================================================
// Watchdog modes
`define VIT_WDT_INTERVAL 2'h0
`define VIT_WDT_NMI      2'h1
`define VIT_WDT_RESET    2'h2

// ====================================================================
// Vectors
`define VIT_VEC_RESTART  16'h0000
`define VIT_VEC_WDT      16'h0004
`define VIT_VEC_STEP     16'h0002

`endif

// File: vit_edge.v
// Per-bit edge detector for synchronous port inputs
`timescale 1ns/100ps
`default_nettype none

module vit_edge #(
  parameter W = 7
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Lines
  input  wire [W-1:0] sig_in,
  input  wire [W-1:0] fall_sel,
  output wire [W-1:0] edge_pulse
);

  reg [W-1:0] prev_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= {W{1'b0}};
    end else begin
      prev_r <= sig_in;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      assign edge_pulse[i] = fall_sel[i] ? (prev_r[i] & ~sig_in[i])
                                         : (~prev_r[i] & sig_in[i]);
    end
  endgenerate

endmodule

`default_nettype wire

// File: vit_top.v
// Interrupt request, mask, priority and vector selection with APB access
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "vit_defines.vh"

// Notes on behaviour
// - Reset or watchdog reset mode restarts 0000.
// - NMI mode watchdog sets flag, vector 0004.
// - Interval mode watchdog is maskable on 0004.
// - External edges zero to six, 0006-0012.
// - Up/down match shares external three flags.
// - Clocked serial zero/one request 0014/0016.
// - Async reception error requests 0018 separately.
// - Async rx and three-wire share 001A.
// - Async transmission end requests 001C.
// - Watch interval signal requests 001E.
// - Timer16 capture/compare requests 0020, 0022.
// - Timer8 matches request 0024 and 0026.
// - Conversion done requests 0028.
// - Equal priority resolved by source order.
// - Test sources never vector, may wake.
// - Watch overflow is masked test source.
// - Key-return falling edge is test source.
// - Mask flags reset to all ones.
// - Priority flags reset to all ones.
// - Request flags reset to zero.
module vit_top (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Event sources, one-cycle pulses
  input  wire        watchdog_irq,
  input  wire        updown_match_irq,
  input  wire        csync0_done_irq,
  input  wire        csync1_done_irq,
  input  wire        async_rx_error_irq,
  input  wire        async_rx_done_irq,
  input  wire        threewire2_done_irq,
  input  wire        async_tx_done_irq,
  input  wire        watch_interval_irq,
  input  wire        timer16_cc0_irq,
  input  wire        timer16_cc1_irq,
  input  wire        timer8a_match_irq,
  input  wire        timer8b_match_irq,
  input  wire        conv_done_irq,
  input  wire        watch_overflow_test,
  // Port levels
  input  wire [6:0]  ext_pins,
  input  wire        key_return_test,
  // Processor core side
  input  wire        int_ack,
  input  wire        nmi_ack,
  output wire        int_pending,
  output wire        nmi_pending,
  output reg         core_restart,
  output reg  [15:0] vector_addr,
  output wire        standby_wake
);

  localparam NM = `VIT_NMSK;
  localparam NF = `VIT_NFLG;

  // ==================================================================
  // Flag state
  reg  [NF-1:0] request_flags_r;
  reg  [NF-1:0] request_flags_nxt;
  reg  [NF-1:0] mask_flags_r;
  reg  [NM-1:0] priority_flags_r;
  reg  [6:0]    edge_fall_r;
  reg  [1:0]    wdt_mode_r;
  reg  [4:0]    sel_idx_r;
  reg           sel_vld_r;

  wire [NF-1:0] ev_set;
  wire [6:0]    ext_edge;
  wire          key_edge;
  wire          wr_en;
  wire          rd_en;
  wire          known;

  // ==================================================================
  // Edge detection on port inputs
  // ext edge detect
  vit_edge #(
    .W (7)
  ) u_ext_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .sig_in     (ext_pins),
    .fall_sel   (edge_fall_r),
    .edge_pulse (ext_edge)
  );

  vit_edge #(
    .W (1)
  ) u_key_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .sig_in     (key_return_test),
    .fall_sel   (1'b1),
    .edge_pulse (key_edge)
  );

  // ==================================================================
  // Source mapping onto request flags
  // watchdog sets flag unless reset mode
  assign ev_set[`VIT_BIT_WDT]   = watchdog_irq & (wdt_mode_r != `VIT_WDT_RESET);
  assign ev_set[`VIT_BIT_EXT0]  = ext_edge[0];
  assign ev_set[2]              = ext_edge[1];
  assign ev_set[3]              = ext_edge[2];
  assign ev_set[`VIT_BIT_EXT3]  = ext_edge[3] | updown_match_irq;
  assign ev_set[5]              = ext_edge[4];
  assign ev_set[6]              = ext_edge[5];
  assign ev_set[7]              = ext_edge[6];
  assign ev_set[`VIT_BIT_CSI0]  = csync0_done_irq;
  assign ev_set[`VIT_BIT_CSI1]  = csync1_done_irq;
  assign ev_set[`VIT_BIT_RXERR] = async_rx_error_irq;
  assign ev_set[`VIT_BIT_RX2]   = async_rx_done_irq | threewire2_done_irq;
  assign ev_set[`VIT_BIT_TX2]   = async_tx_done_irq;
  assign ev_set[`VIT_BIT_WTINT] = watch_interval_irq;
  assign ev_set[`VIT_BIT_CC0]   = timer16_cc0_irq;
  assign ev_set[`VIT_BIT_CC1]   = timer16_cc1_irq;
  assign ev_set[`VIT_BIT_TM8A]  = timer8a_match_irq;
  assign ev_set[`VIT_BIT_TM8B]  = timer8b_match_irq;
  assign ev_set[`VIT_BIT_CONV]  = conv_done_irq;
  assign ev_set[`VIT_BIT_WTOVF] = watch_overflow_test;
  assign ev_set[`VIT_BIT_KEY]   = key_edge;

  // ==================================================================
  // APB decode
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign known  = (paddr == `VIT_OFS_REQ)  | (paddr == `VIT_OFS_MASK) |
                  (paddr == `VIT_OFS_PRIO) | (paddr == `VIT_OFS_EDGE) |
                  (paddr == `VIT_OFS_CTRL) | (paddr == `VIT_OFS_VEC);
  assign pslverr = psel & penable & ~known;

  // Bus fields come in as arguments: @* does not see names read inside a function
  function hit;
    input        en;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = en & (a == ofs);
    end
  endfunction

  // ==================================================================
  // Priority selection
  wire          nmi_mode;
  wire [NM-1:0] live;
  wire [NM-1:0] live_hi;
  wire          any_hi;
  wire [4:0]    idx_hi;
  wire [4:0]    idx_lo;
  wire [4:0]    pick;
  wire          pick_vld;
  wire [NF-1:0] served;

  assign nmi_mode = (wdt_mode_r == `VIT_WDT_NMI);

  assign live = request_flags_r[NM-1:0] & ~mask_flags_r[NM-1:0] &
                ~({{(NM-1){1'b0}}, nmi_mode});
  assign live_hi = live & ~priority_flags_r;
  assign any_hi  = |live_hi;

  // Lowest index wins, matching default order
  function [4:0] first_set;
    input [NM-1:0] v;
    integer k;
    begin
      first_set = 5'h00;
      for (k = NM - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[4:0];
        end
      end
    end
  endfunction

  assign idx_hi   = first_set(live_hi);
  assign idx_lo   = first_set(live);
  // cleared priority first, then source order
  assign pick     = any_hi ? idx_hi : idx_lo;
  assign pick_vld = |live;

  assign nmi_pending = nmi_mode & request_flags_r[`VIT_BIT_WDT];
  assign int_pending = sel_vld_r;

  // wake on any unmasked flag, test sources too
  assign standby_wake = |(request_flags_r & ~mask_flags_r);

  // Acknowledge clears the presented source
  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_srv
      if (g < NM) begin : g_m
        assign served[g] = (int_ack & sel_vld_r & (sel_idx_r == g)) |
                           ((g == `VIT_BIT_WDT) & nmi_ack & nmi_mode);
      end else begin : g_t
        assign served[g] = 1'b0;
      end
    end
  endgenerate

  // ==================================================================
  // Request flag next state: set beats clear
  always @* begin
    request_flags_nxt = request_flags_r & ~served;
    if (hit(wr_en, paddr, `VIT_OFS_REQ)) begin
      request_flags_nxt = pwdata[NF-1:0];
    end
    request_flags_nxt = request_flags_nxt | ev_set;
  end

  // ==================================================================
  // Registers
  // reset values
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_flags_r  <= `VIT_RST_REQ;
      mask_flags_r     <= `VIT_RST_MASK;
      priority_flags_r <= `VIT_RST_PRIO;
      edge_fall_r      <= `VIT_RST_EDGE;
      wdt_mode_r       <= `VIT_RST_CTRL;
    end else begin
      request_flags_r <= request_flags_nxt;
      if (hit(wr_en, paddr, `VIT_OFS_MASK)) begin
        mask_flags_r <= pwdata[NF-1:0];
      end
      if (hit(wr_en, paddr, `VIT_OFS_PRIO)) begin
        priority_flags_r <= pwdata[NM-1:0];
      end
      if (hit(wr_en, paddr, `VIT_OFS_EDGE)) begin
        edge_fall_r <= pwdata[6:0];
      end
      if (hit(wr_en, paddr, `VIT_OFS_CTRL)) begin
        wdt_mode_r <= pwdata[1:0];
      end
    end
  end

  // ==================================================================
  // Vector output toward the core
  // restart through 0000 after reset or watchdog reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_restart <= 1'b1;
      vector_addr  <= `VIT_VEC_RESTART;
      sel_idx_r    <= 5'h00;
      sel_vld_r    <= 1'b0;
    end else begin
      core_restart <= watchdog_irq & (wdt_mode_r == `VIT_WDT_RESET);
      sel_idx_r    <= pick;
      // Pick drops at once after an ack so no double service
      sel_vld_r    <= pick_vld & ~(int_ack & sel_vld_r & (pick == sel_idx_r));
      if (watchdog_irq & (wdt_mode_r == `VIT_WDT_RESET)) begin
        vector_addr <= `VIT_VEC_RESTART;
      end else if (nmi_pending) begin
        vector_addr <= `VIT_VEC_WDT;
      end else if (pick_vld) begin
        // vectors two bytes apart by source order
        vector_addr <= `VIT_VEC_WDT + {10'h000, pick, 1'b0};
      end
    end
  end

  // ==================================================================
  // Read mux; unused high bits read zero
  // test flags visible for software
  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (paddr)
        `VIT_OFS_REQ:  prdata = {11'h000, request_flags_r};
        `VIT_OFS_MASK: prdata = {11'h000, mask_flags_r};
        `VIT_OFS_PRIO: prdata = {13'h0000, priority_flags_r};
        `VIT_OFS_EDGE: prdata = {25'h0000000, edge_fall_r};
        `VIT_OFS_CTRL: prdata = {30'h00000000, wdt_mode_r};
        `VIT_OFS_VEC:  prdata = {13'h0000, standby_wake, nmi_pending,
                                 sel_vld_r, vector_addr};
        default:       prdata = 32'h00000000;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: vit_properties.sv
// Port-level checks of the vectored interrupt table
`timescale 1ns/100ps
`default_nettype none
module vit_properties (
  // Clock, reset, bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sources and core side
  input wire logic        watchdog_irq,
  input wire logic        nmi_ack,
  input wire logic        int_pending,
  input wire logic        nmi_pending,
  input wire logic        core_restart,
  input wire logic [15:0] vector_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Watchdog mode as last written on the bus
  logic [1:0] mode_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode_r <= 2'h0;
    else if (psel && penable && pwrite && paddr == 12'h010)
      mode_r <= pwdata[1:0];
  end
  // ==========================================
  // Assertions
  restart_at_release_a: assert property ($rose(presetn) |-> core_restart)
    else $error("restart low at reset release");
  restart_fire_a: assert property (watchdog_irq && mode_r == 2'h2 |=> core_restart)
    else $error("no restart on watchdog overflow");
  // Release edge samples reset low, so the restart cycle after it is skipped
  restart_cause_a: assert property (presetn && !(watchdog_irq && mode_r == 2'h2)
    |=> !core_restart)
    else $error("restart without cause");
  nmi_raise_a: assert property (watchdog_irq && mode_r == 2'h1 |=> nmi_pending)
    else $error("no nmi on watchdog overflow");
  nmi_vector_a: assert property ($rose(nmi_pending) |=> vector_addr == 16'h0004)
    else $error("nmi vector wrong");
  nmi_clear_a: assert property (nmi_ack && !watchdog_irq |=> !nmi_pending)
    else $error("nmi stays after ack");
  vector_range_a: assert property (int_pending |-> !vector_addr[0] &&
    vector_addr >= 16'h0004 && vector_addr <= 16'h0028)
    else $error("vector outside table");
  bus_ready_a: assert property (psel |-> pready)
    else $error("pready low");
  bus_unmapped_a: assert property (psel && penable &&
    (paddr > 12'h014 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on unmapped access");
endmodule
bind vit_top vit_properties vit_properties_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .watchdog_irq(watchdog_irq), .nmi_ack(nmi_ack),
  .int_pending(int_pending), .nmi_pending(nmi_pending), .core_restart(core_restart),
  .vector_addr(vector_addr));
`default_nettype wire

// File: vit_core_model.sv
// Processor core model that accepts presented vectors
`timescale 1ns/100ps
`default_nettype none
module vit_core_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Controller side
  input  wire logic        int_pending,
  input  wire logic        nmi_pending,
  input  wire logic [15:0] vector_addr,
  output var  logic        int_ack,
  output var  logic        nmi_ack,
  // Bench control and record
  input  wire logic        stall,
  input  wire logic [3:0]  slow,
  output var  logic [15:0] last_vec,
  output var  int          n_int,
  output var  int          n_nmi
);
  logic [4:0] wait_r;
  logic       nmi_d;
  logic       take_nmi;
  // Nmi vector settles a cycle after the flag, so it is taken one cycle late
  assign take_nmi = nmi_pending && nmi_d;
  // At least three idle cycles after an ack, plus slow more, so the next vector has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {int_ack, nmi_ack, nmi_d, wait_r, last_vec} <= '0;
      n_int <= 0;
      n_nmi <= 0;
    end else begin
      nmi_d <= nmi_pending;
      if (int_ack || nmi_ack) begin
        int_ack <= 1'b0;
        nmi_ack <= 1'b0;
        wait_r <= 5'h0;
      end else if ((int_pending || take_nmi) && !stall && wait_r > slow + 5'h1) begin
        nmi_ack <= take_nmi;
        int_ack <= !take_nmi;
        last_vec <= vector_addr;
        n_int <= n_int + int'(!take_nmi);
        n_nmi <= n_nmi + int'(take_nmi);
      end else if (wait_r != 5'h1f)
        wait_r <= wait_r + 5'h1;
    end
  end
endmodule
`default_nettype wire

// File: vit_tb.sv
// Self-checking bench of the vectored interrupt table
`timescale 1ns/100ps
`default_nettype none
`include "vit_defines.vh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, key, stall, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [14:0] ev;
  logic [13:0] e;
  logic [6:0]  ext;
  logic [3:0]  slow;
  logic [20:0] q, mm;
  logic [18:0] pr;
  wire         pready, pslverr, int_ack, nmi_ack, int_pending, nmi_pending;
  wire         core_restart, standby_wake;
  wire  [31:0] prdata;
  wire  [15:0] vector_addr, last_vec;
  int          miscompares, n_tests, n_int, n_nmi, seed, k, b, m;
  vit_top vit_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .watchdog_irq(ev[0]), .updown_match_irq(ev[1]),
    .csync0_done_irq(ev[2]), .csync1_done_irq(ev[3]), .async_rx_error_irq(ev[4]),
    .async_rx_done_irq(ev[5]), .threewire2_done_irq(ev[6]), .async_tx_done_irq(ev[7]),
    .watch_interval_irq(ev[8]), .timer16_cc0_irq(ev[9]), .timer16_cc1_irq(ev[10]),
    .timer8a_match_irq(ev[11]), .timer8b_match_irq(ev[12]), .conv_done_irq(ev[13]),
    .watch_overflow_test(ev[14]), .ext_pins(ext), .key_return_test(key),
    .int_ack(int_ack), .nmi_ack(nmi_ack), .int_pending(int_pending),
    .nmi_pending(nmi_pending), .core_restart(core_restart), .vector_addr(vector_addr),
    .standby_wake(standby_wake));
  vit_core_model vit_core_model_i (.pclk(pclk), .presetn(presetn),
    .int_pending(int_pending), .nmi_pending(nmi_pending), .vector_addr(vector_addr),
    .int_ack(int_ack), .nmi_ack(nmi_ack), .stall(stall), .slow(slow),
    .last_vec(last_vec), .n_int(n_int), .n_nmi(n_nmi));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================
  // Expectations
  function automatic int bitof(input int i);
    int map[15] = '{0, 4, 8, 9, 10, 11, 11, 12, 13, 14, 15, 16, 17, 18, 19};
    return map[i];
  endfunction
  function automatic logic [20:0] reqs(input logic [13:0] s);
    reqs = '0;
    for (int i = 0; i < 14; i++) if (s[i]) reqs[bitof(i)] = 1'b1;
  endfunction
  function automatic logic [15:0] best(input logic [20:0] f, input logic [18:0] p);
    best = 16'h0;
    for (int i = 18; i >= 0; i--) if (f[i] && !p[i]) best = 16'h4 + 16'(2 * i);
    if (best == 16'h0)
      for (int i = 18; i >= 0; i--) if (f[i]) best = 16'h4 + 16'(2 * i);
  endfunction
  // ==========================================
  // Bus and wait tasks
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin miscompares++; tally_and_finish; end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", x, rd)
  endtask
  task automatic pulse(input logic [14:0] s, input logic [6:0] x);
    @(posedge pclk);
    ev <= s; ext <= x;
    @(posedge pclk);
    ev <= '0; ext <= '0;
  endtask
  task automatic wait_ack(input int n0);
    int t;
    for (t = 0; t < 80 && n_int + n_nmi == n0; t++) @(posedge pclk);
    if (n_int + n_nmi == n0) begin miscompares++; tally_and_finish; end
  endtask
  // ==========================================
  // Scenarios
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, ext, stall, slow} = '0;
    key = 1'b1;
    miscompares = 0; n_tests = 0; seed = 32'hf9bd;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`VIT_OFS_REQ, `VIT_RST_REQ);
    rchk(`VIT_OFS_MASK, `VIT_RST_MASK);
    rchk(`VIT_OFS_PRIO, `VIT_RST_PRIO);
    apb(1'b1, 12'h018, 32'h1);
    `CHK("pslverr", 1'b1, err)
    apb(1'b1, `VIT_OFS_MASK, 32'h0);
    // Every vectored source once, core at random speed
    for (k = 0; k < 21; k++) begin
      slow <= 4'($random(seed));
      b = k < 14 ? bitof(k) : k - 13;
      m = n_int + n_nmi;
      pulse(k < 14 ? 15'(1 << k) : 15'h0, k < 14 ? 7'h0 : 7'(1 << (k - 14)));
      wait_ack(m);
      `CHK("vector", 16'h4 + 16'(2 * b), last_vec)
    end
    // Random bursts with masks and priorities, core stalled
    for (k = 0; k < 40; k++) begin
      stall <= 1'b1;
      mm = 21'($random(seed) & $random(seed));
      pr = 19'($random(seed));
      e = 14'($random(seed));
      q = reqs(e);
      apb(1'b1, `VIT_OFS_PRIO, 32'(pr));
      apb(1'b1, `VIT_OFS_MASK, 32'(mm));
      pulse({1'b0, e}, 7'h0);
      repeat (2) @(posedge pclk);
      `CHK("int_pending", |(q & ~mm), int_pending)
      `CHK("vector", best(q & ~mm, pr), int_pending ? vector_addr : 16'h0)
      rchk(`VIT_OFS_REQ, 32'(q));
      stall <= 1'b0;
      apb(1'b1, `VIT_OFS_REQ, 32'h0);
    end
    // Falling-edge selection: a rising pin sets nothing, its fall does
    apb(1'b1, `VIT_OFS_EDGE, 32'h7f);
    apb(1'b1, `VIT_OFS_MASK, 32'h1fffff);
    ext <= 7'h08;
    rchk(`VIT_OFS_REQ, 32'h0);
    ext <= 7'h00;
    rchk(`VIT_OFS_REQ, 32'h10);
    apb(1'b1, `VIT_OFS_REQ, 32'h0);
    // Test sources only wake
    apb(1'b1, `VIT_OFS_MASK, 32'h0);
    key <= 1'b0;
    pulse(15'h4000, 7'h0);
    key <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("int_pending", 1'b0, int_pending)
    `CHK("standby_wake", 1'b1, standby_wake)
    rchk(`VIT_OFS_REQ, 32'h180000);
    apb(1'b1, `VIT_OFS_MASK, 32'h180000);
    @(posedge pclk);
    `CHK("standby_wake", 1'b0, standby_wake)
    // Watchdog as nmi, then as restart
    apb(1'b1, `VIT_OFS_MASK, 32'h1fffff);
    apb(1'b1, `VIT_OFS_CTRL, 32'h1);
    m = n_nmi;
    pulse(15'h1, 7'h0);
    wait_ack(n_int + m);
    `CHK("n_nmi", m + 1, n_nmi)
    `CHK("nmi vector", 16'h0004, last_vec)
    apb(1'b1, `VIT_OFS_CTRL, 32'h2);
    pulse(15'h1, 7'h0);
    @(posedge pclk);
    `CHK("core_restart", 1'b1, core_restart)
    rchk(`VIT_OFS_REQ, 32'h180000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`VIT_OFS_MASK, `VIT_RST_MASK);
    tally_and_finish;
  end
endmodule
`default_nettype wire
